// ---- hw/brgl_cfg.svh ----
// constants for the breaker status, reclose and global setting logic
// ****************************************************************
// How it works
// - group change clears demand when option set
// - zero close-fail time: close drops on closed/trip
// - group changes after inputs hold for delay
// - phase torque control, plain or inverted input
// - residual torque control, plain or inverted input
// - permit, direct close, monitor need breaker status
// - event trigger input; unassigned input does nothing
// - plain status: reclose initiated by trip assert
// - plain status: open interval after trip, open
// - reclose status: closed-to-open initiates reclose
// - open interval waits for trip to drop
// - permit input blocks reclosing when deenergized, inverted one when energized
// - reclose status: opening qualified ten cycles
// - message routing 1 port one, 2 two, 3 both
// - auto messages on untimed-out designated ports
// ****************************************************************
`ifndef BRGL_CFG_SVH
`define BRGL_CFG_SVH
`define BRGL_ADDR_CTRL      12'h000
`define BRGL_ADDR_CFT       12'h004
`define BRGL_ADDR_TGR       12'h008
`define BRGL_ADDR_FUNC_LO   12'h00c
`define BRGL_ADDR_FUNC_HI   12'h010
`define BRGL_ADDR_STATUS    12'h014
`define BRGL_ADDR_RELAYCNT  12'h018
`define BRGL_ADDR_EXTCNT    12'h01c
`define BRGL_ADDR_EVENTS    12'h020
`define BRGL_FUNC_W         5
`define BRGL_TMR_W          14
`define BRGL_CNT_W          16
`define BRGL_CFT_MAX        14'h3e80
`define BRGL_TGR_MAX        14'h3e80
`define BRGL_QUAL_CYC       14'h000a
`define BRGL_CTRL_DEMAND_RESET_ON_GROUP_CHANGE      0
`define BRGL_CTRL_AUTO_LO   1
`define BRGL_CTRL_AUTO_HI   2
`define BRGL_CTRL_GRP_LO    3
`define BRGL_CTRL_GRP_HI    5
`define BRGL_CTRL_RESET     32'h0000_0003
`define BRGL_AUTO_P1        2'h1
`define BRGL_AUTO_P2        2'h2
`define BRGL_AUTO_BOTH      2'h3
`define BRGL_NUM_IN         6
`endif

// ---- hw/brgl_pkg.sv ----
// types for the breaker status, reclose and global setting logic
package brgl_pkg;
	typedef enum logic [4:0]
	{
		BRGL_F_NONE     = 5'h00,
		BRGL_F_SS_A     = 5'h01,
		BRGL_F_SS_B     = 5'h02,
		BRGL_F_SS_C     = 5'h03,
		BRGL_F_TCP      = 5'h04,
		BRGL_F_TCP_INV  = 5'h05,
		BRGL_F_TCG      = 5'h06,
		BRGL_F_TCG_INV  = 5'h07,
		BRGL_F_BRK      = 5'h08,
		BRGL_F_BRK_INV  = 5'h09,
		BRGL_F_BRKR     = 5'h0a,
		BRGL_F_BRKR_INV = 5'h0b,
		BRGL_F_DC       = 5'h0c,
		BRGL_F_RE       = 5'h0d,
		BRGL_F_RE_INV   = 5'h0e,
		BRGL_F_TCM      = 5'h0f,
		BRGL_F_ET       = 5'h10
	} brgl_func_t;
	typedef enum logic [1:0]
	{
		BRGL_S_CLOSED  = 2'b00,
		BRGL_S_QUAL    = 2'b01,
		BRGL_S_OPEN    = 2'b11
	} brgl_brk_t;
	typedef struct packed
	{
		logic phaseTorqueEn;
		logic residTorqueEn;
		logic directClose;
		logic tripCircuitMon;
		logic eventTrigger;
		logic reclosePermit;
	} brgl_ctl_t;
	typedef struct packed
	{
		logic recloseInit;
		logic openIntervalStart;
		logic relayTripCount;
		logic extTripCount;
		logic demandReset;
		logic groupChanged;
	} brgl_evt_t;
endpackage

// ---- hw/brgl_timer.sv ----
// loadable down counter with done flag
`timescale 1ns/1ps
`include "brgl_cfg.svh"
module brgl_timer
	import brgl_pkg::*;
#(
	parameter int W = `BRGL_TMR_W
)
(
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic         ce,
	input  wire logic         start,
	input  wire logic         clear,
	input  wire logic [W-1:0] count,
	output logic              running,
	output logic              done
);
	initial
	begin
		if (W < 4)
			$error("brgl_timer width too small");
	end
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic         run_q;
	logic         run_d;
	logic         done_q;
	logic         done_d;
	always_comb
	begin
		cnt_d = cnt_q;
		run_d = run_q;
		done_d = 1'b0;
		if (clear)
		begin
			run_d = 1'b0;
		end
		else if (start)
		begin
			cnt_d = count;
			run_d = (count != '0);
			done_d = (count == '0);
		end
		else if (run_q)
		begin
			if (cnt_q <= W'(1))
			begin
				run_d = 1'b0;
				done_d = 1'b1;
				cnt_d = '0;
			end
			else
				cnt_d = cnt_q - W'(1);
		end
	end
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_q <= '0;
			run_q <= 1'b0;
			done_q <= 1'b0;
		end
		else if (ce)
		begin
			cnt_q <= cnt_d;
			run_q <= run_d;
			done_q <= done_d;
		end
	end
	assign running = run_q;
	assign done = done_q;
endmodule

// ---- hw/brgl_top.sv ----
// breaker status, reclose and global setting logic with apb registers
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
`include "brgl_cfg.svh"
module brgl_top
	import brgl_pkg::*;
#(
	parameter int NIN = `BRGL_NUM_IN
)
(
	input  wire logic            clk,
	input  wire logic            rstn,
	input  wire logic            ce,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [11:0]     paddr,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	input  wire logic [NIN-1:0]  contactIn,
	input  wire logic            tripIn,
	input  wire logic            closeCmd,
	input  wire logic            portOneTimedOut,
	input  wire logic            portTwoTimedOut,
	input  wire logic            autoMsgReq,
	output logic                 closeOut,
	output brgl_ctl_t            ctl,
	output brgl_evt_t            evt,
	output logic      [2:0]      activeGroup,
	output logic                 breakerOpen,
	output logic                 autoToPortOne,
	output logic                 autoToPortTwo
);
	initial
	begin
		if (NIN != 6)
			$error("brgl_top needs six contact inputs");
	end
	// ****************************************************************
	// input synchronisers
	// ****************************************************************
	logic [NIN-1:0] sync1_q;
	logic [NIN-1:0] sync2_q;
	logic           trip1_q;
	logic           trip2_q;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
			trip1_q <= 1'b0;
			trip2_q <= 1'b0;
		end
		else if (ce)
		begin
			sync1_q <= contactIn;
			sync2_q <= sync1_q;
			trip1_q <= tripIn;
			trip2_q <= trip1_q;
		end
	end
	// ****************************************************************
	// register file
	// ****************************************************************
	logic [31:0]               ctrl_q;
	logic [31:0]               ctrl_d;
	logic [`BRGL_TMR_W-1:0]    cft_q;
	logic [`BRGL_TMR_W-1:0]    cft_d;
	logic [`BRGL_TMR_W-1:0]    tgr_q;
	logic [`BRGL_TMR_W-1:0]    tgr_d;
	logic [NIN*`BRGL_FUNC_W-1:0] func_q;
	logic [NIN*`BRGL_FUNC_W-1:0] func_d;
	logic [31:0]               rd_d;
	logic                      err_d;
	logic                      acc;
	logic [`BRGL_CNT_W-1:0]    relayCnt_q;
	logic [`BRGL_CNT_W-1:0]    extCnt_q;
	logic [5:0]                evtSticky_q;
	logic                      evtClr;
	logic                      brkInvalid;
	assign acc = psel && penable && ce;
	always_comb
	begin
		ctrl_d = ctrl_q;
		cft_d = cft_q;
		tgr_d = tgr_q;
		func_d = func_q;
		rd_d = 32'h0000_0000;
		err_d = 1'b0;
		evtClr = 1'b0;
		case (paddr)
			`BRGL_ADDR_CTRL:
				rd_d = {26'h0, activeGroup, ctrl_q[`BRGL_CTRL_AUTO_HI:0]};
			`BRGL_ADDR_CFT:
				rd_d = {18'h0, cft_q};
			`BRGL_ADDR_TGR:
				rd_d = {18'h0, tgr_q};
			`BRGL_ADDR_FUNC_LO:
				rd_d = {17'h0, func_q[14:0]};
			`BRGL_ADDR_FUNC_HI:
				rd_d = {17'h0, func_q[29:15]};
			`BRGL_ADDR_STATUS:
				rd_d = {27'h0, closeOut, breakerOpen, brkInvalid, sync2_q[1:0]};
			`BRGL_ADDR_RELAYCNT:
				rd_d = {16'h0, relayCnt_q};
			`BRGL_ADDR_EXTCNT:
				rd_d = {16'h0, extCnt_q};
			`BRGL_ADDR_EVENTS:
				rd_d = {26'h0, evtSticky_q};
			default:
				err_d = 1'b1;
		endcase
		if (acc && pwrite && !err_d)
		begin
			case (paddr)
				`BRGL_ADDR_CTRL:
					ctrl_d = {26'h0, pwdata[`BRGL_CTRL_GRP_HI:0]};
				`BRGL_ADDR_CFT:
					cft_d = (pwdata[`BRGL_TMR_W-1:0] > `BRGL_CFT_MAX) ? `BRGL_CFT_MAX
						: pwdata[`BRGL_TMR_W-1:0];
				`BRGL_ADDR_TGR:
					tgr_d = (pwdata[`BRGL_TMR_W-1:0] > `BRGL_TGR_MAX) ? `BRGL_TGR_MAX
						: pwdata[`BRGL_TMR_W-1:0];
				`BRGL_ADDR_FUNC_LO:
					func_d[14:0] = pwdata[14:0];
				`BRGL_ADDR_FUNC_HI:
					func_d[29:15] = pwdata[14:0];
				`BRGL_ADDR_EVENTS:
					evtClr = 1'b1;
				default:
					ctrl_d = ctrl_q;
			endcase
		end
	end
	// ****************************************************************
	// input function decode
	// ****************************************************************
	logic [NIN-1:0] isTcp, isTcpI, isTcg, isTcgI, isBrk, isBrkI, isBrkR, isBrkRI;
	logic [NIN-1:0] isDc, isRe, isReI, isTcm, isEt;
	logic [2:0]     ssVal;
	logic [2:0]     ssAssigned;
	genvar gi;
	generate
		for (gi = 0; gi < NIN; gi++)
		begin : g_dec
			brgl_func_t f;
			assign f = brgl_func_t'(func_q[gi*`BRGL_FUNC_W +: `BRGL_FUNC_W]);
			assign isTcp[gi] = (f == BRGL_F_TCP) && sync2_q[gi];
			assign isTcpI[gi] = (f == BRGL_F_TCP_INV) && !sync2_q[gi];
			assign isTcg[gi] = (f == BRGL_F_TCG) && sync2_q[gi];
			assign isTcgI[gi] = (f == BRGL_F_TCG_INV) && !sync2_q[gi];
			assign isBrk[gi] = (f == BRGL_F_BRK);
			assign isBrkI[gi] = (f == BRGL_F_BRK_INV);
			assign isBrkR[gi] = (f == BRGL_F_BRKR);
			assign isBrkRI[gi] = (f == BRGL_F_BRKR_INV);
			assign isDc[gi] = (f == BRGL_F_DC) && sync2_q[gi];
			assign isRe[gi] = (f == BRGL_F_RE);
			assign isReI[gi] = (f == BRGL_F_RE_INV);
			assign isTcm[gi] = (f == BRGL_F_TCM) && sync2_q[gi];
			assign isEt[gi] = (f == BRGL_F_ET) && sync2_q[gi];
		end
	endgenerate
	// group select only honoured on its own fixed input
	assign ssAssigned[0] = brgl_func_t'(func_q[4:0]) == BRGL_F_SS_A;
	assign ssAssigned[1] = brgl_func_t'(func_q[9:5]) == BRGL_F_SS_B;
	assign ssAssigned[2] = brgl_func_t'(func_q[14:10]) == BRGL_F_SS_C;
	assign ssVal = ssAssigned & sync2_q[2:0];
	logic anyPlain, anyRecl, brkAssigned, rawClosed;
	logic [NIN-1:0] closedVec;
	assign anyPlain = |(isBrk | isBrkI);
	assign anyRecl = |(isBrkR | isBrkRI);
	assign brkAssigned = anyPlain | anyRecl;
	assign brkInvalid = ($countones(isBrk | isBrkI | isBrkR | isBrkRI) > 1);
	assign closedVec = ((isBrk | isBrkR) & sync2_q) | ((isBrkI | isBrkRI) & ~sync2_q);
	assign rawClosed = |closedVec;
	// ****************************************************************
	// breaker status qualification and reclose
	// ****************************************************************
	brgl_brk_t brk_q, brk_d;
	logic      qualStart, qualDone, qualRun;
	logic      trip_q, pendOpen_q, pendOpen_d, permit;
	brgl_evt_t evt_d;
	brgl_ctl_t ctl_d;
	logic      close_d, close_q, cftStart, cftDone, cftRun;
	brgl_timer #(.W(`BRGL_TMR_W)) u_qual
	(
		.clk     (clk),
		.rstn    (rstn),
		.ce      (ce),
		.start   (qualStart),
		.clear   (rawClosed),
		.count   (`BRGL_QUAL_CYC),
		.running (qualRun),
		.done    (qualDone)
	);
	assign permit = !(|(isRe | isReI)) || |((isRe & sync2_q) | (isReI & ~sync2_q));
	always_comb
	begin
		brk_d = brk_q;
		qualStart = 1'b0;
		pendOpen_d = pendOpen_q;
		evt_d = '0;
		case (brk_q)
			BRGL_S_CLOSED:
				if (!rawClosed && brkAssigned)
				begin
					if (anyRecl)
					begin
						brk_d = BRGL_S_QUAL;
						qualStart = 1'b1;
					end
					else
					begin
						brk_d = BRGL_S_OPEN;
						evt_d.relayTripCount = trip2_q;
						evt_d.extTripCount = !trip2_q;
					end
				end
			BRGL_S_QUAL:
				if (rawClosed)
					brk_d = BRGL_S_CLOSED;
				else if (qualDone)
				begin
					brk_d = BRGL_S_OPEN;
					evt_d.relayTripCount = trip2_q;
					evt_d.extTripCount = !trip2_q;
					evt_d.recloseInit = permit;
					pendOpen_d = permit;
				end
			BRGL_S_OPEN:
				if (rawClosed)
					brk_d = BRGL_S_CLOSED;
			default:
				brk_d = BRGL_S_CLOSED;
		endcase
		if (anyPlain && trip2_q && !trip_q && permit)
		begin
			evt_d.recloseInit = 1'b1;
			pendOpen_d = 1'b1;
		end
		// open interval waits for trip to fall and breaker open
		if (pendOpen_q && !trip2_q && brk_q == BRGL_S_OPEN && !rawClosed)
		begin
			evt_d.openIntervalStart = 1'b1;
			pendOpen_d = 1'b0;
		end
		if (rawClosed && brk_q != BRGL_S_OPEN)
			pendOpen_d = pendOpen_d & trip2_q;
		ctl_d.phaseTorqueEn = |(isTcp | isTcpI);
		ctl_d.residTorqueEn = |(isTcg | isTcgI);
		ctl_d.directClose = brkAssigned && |isDc;
		ctl_d.tripCircuitMon = brkAssigned && |isTcm;
		ctl_d.reclosePermit = brkAssigned && permit;
		ctl_d.eventTrigger = |isEt;
	end
	// ****************************************************************
	// close output and close failure
	// ****************************************************************
	brgl_timer #(.W(`BRGL_TMR_W)) u_cft
	(
		.clk     (clk),
		.rstn    (rstn),
		.ce      (ce),
		.start   (cftStart),
		.clear   (!close_q),
		.count   (cft_q),
		.running (cftRun),
		.done    (cftDone)
	);
	assign cftStart = closeCmd && !close_q && (cft_q != '0);
	always_comb
	begin
		close_d = close_q;
		if (closeCmd && !close_q)
			close_d = 1'b1;
		else if (close_q && (cft_q == '0) && (rawClosed || trip2_q))
			close_d = 1'b0;
		else if (close_q && (cftDone || trip2_q))
			close_d = 1'b0;
	end
	// ****************************************************************
	// group change delay
	// ****************************************************************
	logic [2:0] pendGrp_q, pendGrp_d, group_q, group_d;
	logic       tgrStart, tgrDone, tgrRun, grpChg;
	brgl_timer #(.W(`BRGL_TMR_W)) u_tgr
	(
		.clk     (clk),
		.rstn    (rstn),
		.ce      (ce),
		.start   (tgrStart),
		.clear   (1'b0),
		.count   (tgr_q),
		.running (tgrRun),
		.done    (tgrDone)
	);
	assign tgrStart = (ssVal != pendGrp_q);
	always_comb
	begin
		pendGrp_d = ssVal;
		group_d = group_q;
		grpChg = 1'b0;
		if (tgrDone && !tgrStart && pendGrp_q != 3'h0 && pendGrp_q != group_q)
		begin
			group_d = pendGrp_q;
			grpChg = 1'b1;
		end
		else if (ssAssigned == 3'h0 || ssVal == 3'h0)
		begin
			if (group_q != ctrl_q[`BRGL_CTRL_GRP_HI:`BRGL_CTRL_GRP_LO]
				&& ctrl_q[`BRGL_CTRL_GRP_HI:`BRGL_CTRL_GRP_LO] != 3'h0)
			begin
				group_d = ctrl_q[`BRGL_CTRL_GRP_HI:`BRGL_CTRL_GRP_LO];
				grpChg = 1'b1;
			end
		end
	end
	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl_q <= `BRGL_CTRL_RESET;
			cft_q <= '0;
			tgr_q <= '0;
			func_q <= '0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			brk_q <= BRGL_S_CLOSED;
			trip_q <= 1'b0;
			pendOpen_q <= 1'b0;
			close_q <= 1'b0;
			pendGrp_q <= 3'h0;
			group_q <= 3'h1;
			evt <= '0;
			ctl <= '0;
			relayCnt_q <= '0;
			extCnt_q <= '0;
			evtSticky_q <= '0;
			closeOut <= 1'b0;
			activeGroup <= 3'h1;
			breakerOpen <= 1'b0;
			autoToPortOne <= 1'b0;
			autoToPortTwo <= 1'b0;
		end
		else if (ce)
		begin
			ctrl_q <= ctrl_d;
			cft_q <= cft_d;
			tgr_q <= tgr_d;
			func_q <= func_d;
			pready <= psel && !penable;
			prdata <= rd_d;
			pslverr <= psel && !penable && err_d;
			brk_q <= brk_d;
			trip_q <= trip2_q;
			pendOpen_q <= pendOpen_d;
			close_q <= close_d;
			pendGrp_q <= pendGrp_d;
			group_q <= group_d;
			evt <= evt_d;
			evt.groupChanged <= grpChg;
			evt.demandReset <= grpChg && ctrl_q[`BRGL_CTRL_DEMAND_RESET_ON_GROUP_CHANGE];
			ctl <= ctl_d;
			relayCnt_q <= relayCnt_q + `BRGL_CNT_W'(evt_d.relayTripCount);
			extCnt_q <= extCnt_q + `BRGL_CNT_W'(evt_d.extTripCount);
			evtSticky_q <= (evtClr ? 6'h00 : evtSticky_q) | evt_d;
			closeOut <= close_d;
			activeGroup <= group_d;
			breakerOpen <= (brk_d == BRGL_S_OPEN);
			autoToPortOne <= autoMsgReq && !portOneTimedOut && ctrl_q[`BRGL_CTRL_AUTO_LO];
			autoToPortTwo <= autoMsgReq && !portTwoTimedOut && ctrl_q[`BRGL_CTRL_AUTO_HI];
		end
	end
endmodule

// ---- tb/brgl_top_asserts.sv ----
// checker of handshake, close, routing and event pulses
`timescale 1ns/1ps
module brgl_top_asserts
	import brgl_pkg::*;
(
	input wire logic      clk,
	input wire logic      rstn,
	input wire logic      psel,
	input wire logic      penable,
	input wire logic      pready,
	input wire logic      pslverr,
	input wire logic      tripIn,
	input wire logic      closeCmd,
	input wire logic      closeOut,
	input wire logic      portOneTimedOut,
	input wire logic      portTwoTimedOut,
	input wire logic      autoToPortOne,
	input wire logic      autoToPortTwo,
	input wire brgl_evt_t evt
);
	// ****
	// properties
	// ****
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence setupPhase;
		psel && !penable;
	endsequence
	sequence accessDone;
		psel && penable && pready;
	endsequence
	a_ready_after_setup: assert property (setupPhase |=> accessDone)
		else $error("no ready after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready held");
	a_error_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_close_on_trip: assert property ((tripIn && !closeCmd)[*5] |-> !closeOut)
		else $error("close kept during trip");
	a_reclose_pulse: assert property (evt.recloseInit |=> !evt.recloseInit)
		else $error("reclose init held");
	a_trip_kinds: assert property (!(evt.relayTripCount && evt.extTripCount))
		else $error("trip counted twice");
	a_demand_grp: assert property (evt.demandReset
		|-> evt.groupChanged || $past(evt.groupChanged)) else $error("demand reset alone");
	a_port_one_quiet: assert property (portOneTimedOut[*3] |-> !autoToPortOne)
		else $error("port one sent after timeout");
	a_port_two_quiet: assert property (portTwoTimedOut[*3] |-> !autoToPortTwo)
		else $error("port two sent after timeout");
endmodule
bind brgl_top brgl_top_asserts brgl_top_asserts_inst (.clk(clk), .rstn(rstn), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .tripIn(tripIn),
	.closeCmd(closeCmd), .closeOut(closeOut), .portOneTimedOut(portOneTimedOut),
	.portTwoTimedOut(portTwoTimedOut), .autoToPortOne(autoToPortOne),
	.autoToPortTwo(autoToPortTwo), .evt(evt));

// ---- tb/brgl_breaker.sv ----
// breaker model giving the closed-position auxiliary contact
`timescale 1ns/1ps
module brgl_breaker
#(
	parameter int MOVE_CYC = 4
)
(
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic closeCoil,
	input  wire logic tripCoil,
	output logic      auxClosed
);
	int holdCnt;
	// mechanism moves after its coil is held for the travel time
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			auxClosed <= 1'b1;
			holdCnt <= 0;
		end
		else if (auxClosed ? tripCoil : closeCoil)
		begin
			holdCnt <= holdCnt + 1;
			if (holdCnt == MOVE_CYC - 1)
			begin
				auxClosed <= !auxClosed;
				holdCnt <= 0;
			end
		end
		else
			holdCnt <= 0;
	end
endmodule

// ---- tb/brgl_top_tb.sv ----
// self-checking bench of the breaker status and global setting logic
`timescale 1ns/1ps
`include "brgl_cfg.svh"
module brgl_top_tb
	import brgl_pkg::*;
;
	logic        clk, rstn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [5:0]  pins, contactIn;
	logic        tripIn, closeCmd, extOpen, closeOut, breakerOpen, auxClosed;
	logic        portOneTimedOut, portTwoTimedOut, autoToPortOne, autoToPortTwo;
	logic [2:0]  activeGroup;
	brgl_ctl_t   ctl;
	brgl_evt_t   evt;
	int          fails, totalChecks;
	int          seen [6];
	// rows: auto field, port one and two timed out, expected port one and two
	localparam logic [5:0] ROWS [6] = '{6'b01_00_10, 6'b10_00_01, 6'b11_00_11,
		6'b11_10_01, 6'b11_01_10, 6'b01_10_00};

	assign contactIn = {pins[5], auxClosed, pins[3:0]};
	brgl_top brgl_top_inst (.clk(clk), .rstn(rstn), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .contactIn(contactIn), .tripIn(tripIn), .closeCmd(closeCmd),
		.portOneTimedOut(portOneTimedOut), .portTwoTimedOut(portTwoTimedOut),
		.autoMsgReq(1'b1), .closeOut(closeOut), .ctl(ctl), .evt(evt),
		.activeGroup(activeGroup), .breakerOpen(breakerOpen),
		.autoToPortOne(autoToPortOne), .autoToPortTwo(autoToPortTwo));
	brgl_breaker brgl_breaker_inst (.clk(clk), .rstn(rstn), .closeCoil(closeOut),
		.tripCoil(tripIn | extOpen), .auxClosed(auxClosed));

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk)
		for (int i = 0; i < 6; i++)
			if (evt[i] === 1'b1)
				seen[i]++;

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		totalChecks++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic results();
		$display("checks %0d failures %0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (3000) @(posedge clk);
		fails++;
		results();
	end

	// ****
	// stimulus
	// ****
	initial
	begin
		{rstn, psel, penable, pwrite, tripIn, closeCmd, extOpen} = 7'h00;
		{portOneTimedOut, portTwoTimedOut, paddr, pwdata, pins} = '0;
		tick(5);
		rstn <= 1'b1;
		tick(1);
		chk("group", 32'h1, activeGroup);
		bus(1'b0, `BRGL_ADDR_CTRL, 32'h0);
		chk("ctrl", 32'hb, rdat);
		bus(1'b0, 12'h100, 32'h0);
		chk("unmapped", 32'h1, rerr);
		bus(1'b1, `BRGL_ADDR_CFT, 32'h3fff);
		bus(1'b0, `BRGL_ADDR_CFT, 32'h0);
		chk("cft", 32'h3e80, rdat);
		bus(1'b1, `BRGL_ADDR_CFT, 32'h0);
		foreach (ROWS[i])
		begin
			bus(1'b1, `BRGL_ADDR_CTRL, {26'h0, 3'h1, ROWS[i][5:4], 1'b1});
			portOneTimedOut <= ROWS[i][3];
			portTwoTimedOut <= ROWS[i][2];
			tick(4);
			chk("port one", {31'h0, ROWS[i][1]}, autoToPortOne);
			chk("port two", {31'h0, ROWS[i][0]}, autoToPortTwo);
		end
		{portOneTimedOut, portTwoTimedOut} <= 2'b00;
		pins <= 6'b000101;
		bus(1'b1, `BRGL_ADDR_FUNC_LO, {17'h0, BRGL_F_RE, BRGL_F_SS_B, BRGL_F_TCP});
		tick(5);
		chk("permit alone", 32'h0, ctl.reclosePermit);
		chk("phase torque", 32'h1, ctl.phaseTorqueEn);
		bus(1'b1, `BRGL_ADDR_FUNC_HI, {17'h0, BRGL_F_ET, BRGL_F_BRKR, BRGL_F_TCG_INV});
		pins[5] <= 1'b1;
		tick(5);
		chk("permit", 32'h1, ctl.reclosePermit);
		chk("resid torque", 32'h1, ctl.residTorqueEn);
		chk("trigger", 32'h1, ctl.eventTrigger);
		pins[2] <= 1'b0;
		tick(5);
		chk("permit off", 32'h0, ctl.reclosePermit);
		pins[2] <= 1'b1;
		bus(1'b1, `BRGL_ADDR_TGR, 32'd20);
		pins[1] <= 1'b1;
		tick(10);
		chk("group held", 32'h1, activeGroup);
		tick(20);
		chk("group new", 32'h2, activeGroup);
		chk("demand clear", 32'h1, seen[1]);
		extOpen <= 1'b1;
		tick(10);
		chk("qualifying", 32'h0, breakerOpen);
		tick(14);
		extOpen <= 1'b0;
		chk("opened", 32'h1, breakerOpen);
		chk("ext count", 32'h1, seen[2]);
		chk("init ext", 32'h1, seen[5]);
		closeCmd <= 1'b1;
		tick(1);
		closeCmd <= 1'b0;
		tick(3);
		chk("close on", 32'h1, closeOut);
		tick(12);
		chk("close off", 32'h0, closeOut);
		tripIn <= 1'b1;
		tick(24);
		chk("interval wait", 32'h1, seen[4]);
		tripIn <= 1'b0;
		tick(8);
		chk("interval go", 32'h2, seen[4]);
		chk("relay count", 32'h1, seen[3]);
		chk("init relay", 32'h2, seen[5]);
		bus(1'b0, `BRGL_ADDR_RELAYCNT, 32'h0);
		chk("relay reg", 32'h1, rdat);
		bus(1'b0, `BRGL_ADDR_EXTCNT, 32'h0);
		chk("ext reg", 32'h1, rdat);
		results();
	end
endmodule
